// >>> common/bpr_pkg.sv
// package for the boot partition read block: offsets, fields, states, carriers
package bpr_pkg;
    localparam logic [11:0] BPR_OFF_INFO    = 12'h040;
    localparam logic [11:0] BPR_OFF_SEL     = 12'h044;
    localparam logic [11:0] BPR_OFF_BUF_LO  = 12'h048;
    localparam logic [11:0] BPR_OFF_BUF_HI  = 12'h04C;
    localparam int          BPR_INFO_ACT    = 31;
    localparam int          BPR_INFO_STS_LO = 24;
    localparam int          BPR_INFO_SZ_W   = 15;
    localparam int          BPR_SEL_PART    = 31;
    localparam int          BPR_SEL_OFS_LO  = 10;
    localparam int          BPR_SEL_OFS_W   = 20;
    localparam int          BPR_SEL_LEN_W   = 10;
    localparam int          BPR_BUF_LO_BIT  = 12;
    localparam int          BPR_PAGE_BITS   = 12;
    localparam int          BPR_SZ_TO_PAGES = 5;
    localparam logic [31:0] BPR_SEL_RST     = 32'h0000_0000;
    localparam logic [63:0] BPR_BUF_RST     = 64'h0000_0000_0000_0000;
    localparam int          BPR_WORD_BYTES  = 4;
    localparam int          BPR_PAGE_WORDS  = 1024;

    typedef enum logic [1:0] {
        BPR_ST_IDLE = 2'b00,
        BPR_ST_BUSY = 2'b01,
        BPR_ST_DONE = 2'b10,
        BPR_ST_ERR  = 2'b11
    } bpr_status_t;

    typedef enum logic [1:0] {
        BPR_FSM_IDLE  = 2'b00,
        BPR_FSM_CHECK = 2'b01,
        BPR_FSM_RUN   = 2'b11,
        BPR_FSM_WAIT  = 2'b10
    } bpr_fsm_t;

    // register access from the controller's memory space
    typedef struct packed {
        logic        wr;
        logic        rd;
        logic [11:0] addr;
        logic [31:0] wdata;
    } bpr_reg_req_t;

    // one word toward host memory
    typedef struct packed {
        logic [63:0] addr;
        logic [31:0] data;
    } bpr_mem_wr_t;

    // one word read request into the flash array
    typedef struct packed {
        logic        part;
        logic [29:0] word;
    } bpr_fl_req_t;
endpackage : bpr_pkg

// >>> logic/bpr_top.sv
// boot partition read sequencer: registers and flash-to-host-memory copy engine
//
// Function
// - without boot partition support the three registers read as zero
// - info register bit 31 shows the active boot partition
// - read status in bits 25:24: idle, busy, done, error
// - writing the select register sets read status to in progress
// - read status becomes done once all data reached the host buffer
// - a failed read sets the read status to error
// - partition size in bits 14:0, units of 128 KiB, same for both
// - offset plus length beyond partition size: no transfer, error status
// - a select write starts a copy from the partition chosen by bit 31
// - start position from select bits 29:10, in 4 KiB pages
// - transfer length from select bits 9:0, in 4 KiB pages
// - destination address from buffer bits 63:12, low twelve bits zero
//
// operation: the copy moves one 32-bit word at a time, flash read first and
// then one host write; the next flash request waits until that write is taken,
// so at most one word is ever held inside the block.
// limitation: throughput is bounded by this one-word hold, a trade for area.
// a new select write always wins and restarts the copy from its first word.
// handshakes: valid stands until ready unless a select write or an error aborts; every payload comes from a flop.
//
`timescale 1ns/1ns
module bpr_top #(
    parameter bit          SUPPORTED  = 1'b1,
    parameter logic [14:0] PART_SIZE  = 15'h0001,
    parameter bit          ACTIVE_ID  = 1'b0
) (
    input  wire logic                  clock_i,
    input  wire logic                  rstn_i,
    input  wire bpr_pkg::bpr_reg_req_t reg_req_i,
    output logic [31:0]                reg_rdata_o,
    output logic                       fl_req_valid_o,
    output bpr_pkg::bpr_fl_req_t       fl_req_o,
    input  wire logic                  fl_req_ready_i,
    input  wire logic                  fl_rsp_valid_i,
    input  wire logic [31:0]           fl_rsp_data_i,
    input  wire logic                  fl_rsp_err_i,
    output logic                       mem_wr_valid_o,
    output bpr_pkg::bpr_mem_wr_t       mem_wr_o,
    input  wire logic                  mem_wr_ready_i,
    input  wire logic                  mem_wr_err_i
);
    import bpr_pkg::*;

    // reset release pair
    logic        rst_meta_r;
    logic        rst_sync_r;

    // host-visible registers
    logic [31:0] sel_r;
    logic [63:0] buf_r;
    bpr_status_t status_r;

    // copy engine state: next word, words still owed, next host address
    bpr_fsm_t    fsm_r;
    logic [29:0] word_r;
    logic [19:0] words_left_r;
    logic [63:0] dst_r;

    // one-word hold between flash answer and host write
    logic        data_full_r;
    logic [31:0] data_r;

    // decoded strobe and range arithmetic
    logic        sel_wr;
    logic [20:0] end_page;
    logic [19:0] size_pages;

    // total pages in a partition: 128 KiB units times 32 pages
    // (4 KiB pages, so a five-bit shift)
    function automatic logic [19:0] part_pages(input logic [14:0] sz);
        part_pages = {sz, 5'b0_0000};
    endfunction : part_pages

    // reset release through two flops, async assert
    // the rest of the design resets on rst_sync_r, so release is always clean
    always_ff @(posedge clock_i or negedge rstn_i) begin
        if (!rstn_i) begin
            rst_meta_r <= 1'b0;
            rst_sync_r <= 1'b0;
        end else begin
            rst_meta_r <= 1'b1;
            rst_sync_r <= rst_meta_r;
        end
    end

    // select write decode; range sum has one spare bit so it cannot wrap
    assign sel_wr     = SUPPORTED && reg_req_i.wr && reg_req_i.addr == BPR_OFF_SEL;
    assign size_pages = part_pages(PART_SIZE);
    assign end_page   = {1'b0, sel_r[BPR_SEL_OFS_LO +: BPR_SEL_OFS_W]}
                      + {11'h000, sel_r[BPR_SEL_LEN_W-1:0]};

    // software-written registers; reserved bits are simply never stored
    // low buffer bits masked on write so the host address stays 4 KiB aligned
    always_ff @(posedge clock_i or negedge rst_sync_r) begin
        if (!rst_sync_r) begin
            sel_r <= BPR_SEL_RST;
            buf_r <= BPR_BUF_RST;
        end else if (SUPPORTED && reg_req_i.wr) begin
            if (reg_req_i.addr == BPR_OFF_SEL) begin
                sel_r <= reg_req_i.wdata & 32'hBFFF_FFFF;
            end
            if (reg_req_i.addr == BPR_OFF_BUF_LO) begin
                buf_r[31:0] <= reg_req_i.wdata & 32'hFFFF_F000;
            end
            // high half has no reserved bits
            if (reg_req_i.addr == BPR_OFF_BUF_HI) begin
                buf_r[63:32] <= reg_req_i.wdata;
            end
        end
    end

    // read mux; unmapped offsets and unsupported builds return zero
    // reads have no side effects, so polling the status is always safe
    always_comb begin
        reg_rdata_o = 32'h0000_0000;
        if (SUPPORTED && reg_req_i.rd) begin
            unique case (reg_req_i.addr)
                // info: active partition, status and size; all else reads zero
                BPR_OFF_INFO: begin
                    reg_rdata_o[BPR_INFO_ACT]                = ACTIVE_ID;
                    reg_rdata_o[BPR_INFO_STS_LO +: 2]        = status_r;
                    reg_rdata_o[BPR_INFO_SZ_W-1:0]           = PART_SIZE;
                end
                BPR_OFF_SEL:    reg_rdata_o = sel_r;
                BPR_OFF_BUF_LO: reg_rdata_o = buf_r[31:0];
                BPR_OFF_BUF_HI: reg_rdata_o = buf_r[63:32];
                default:        reg_rdata_o = 32'h0000_0000;
            endcase
        end
    end

    // copy engine; a new select write restarts it even mid-copy
    // the select write beats every state, so a late answer from an aborted
    // copy lands in idle or check and is ignored there
    always_ff @(posedge clock_i or negedge rst_sync_r) begin
        if (!rst_sync_r) begin
            fsm_r        <= BPR_FSM_IDLE;
            status_r     <= BPR_ST_IDLE;
            word_r       <= 30'h0000_0000;
            words_left_r <= 20'h0_0000;
            dst_r        <= 64'h0000_0000_0000_0000;
        end else if (sel_wr) begin
            fsm_r    <= BPR_FSM_CHECK;
            status_r <= BPR_ST_BUSY;
        end else begin
            unique case (fsm_r)
                // idle: nothing to do until a select write
                BPR_FSM_IDLE: fsm_r <= BPR_FSM_IDLE;
                // load counters from the select and buffer registers, then range check
                BPR_FSM_CHECK: begin
                    word_r       <= {sel_r[BPR_SEL_OFS_LO +: BPR_SEL_OFS_W], 10'h000};
                    words_left_r <= {sel_r[BPR_SEL_LEN_W-1:0], 10'h000};
                    dst_r        <= {buf_r[63:BPR_BUF_LO_BIT], 12'h000};
                    // an out-of-range request moves no data at all
                    if (end_page > {1'b0, size_pages}) begin
                        fsm_r    <= BPR_FSM_IDLE;
                        status_r <= BPR_ST_ERR;
                    // an empty request is reported done with nothing moved
                    end else if (sel_r[BPR_SEL_LEN_W-1:0] == 10'h000) begin
                        fsm_r    <= BPR_FSM_IDLE;
                        status_r <= BPR_ST_DONE;
                    end else begin
                        fsm_r <= BPR_FSM_RUN;
                    end
                end
                // flash request stands until the array takes it
                BPR_FSM_RUN: begin
                    if (fl_req_ready_i) begin
                        fsm_r <= BPR_FSM_WAIT;
                    end
                end
                // wait for the word, then for its host write to be taken
                BPR_FSM_WAIT: begin
                    // any error stops the copy at once and leaves the buffer part-written
                    if ((fl_rsp_valid_i && fl_rsp_err_i) || mem_wr_err_i) begin
                        fsm_r    <= BPR_FSM_IDLE;
                        status_r <= BPR_ST_ERR;
                    end else if (data_full_r && mem_wr_ready_i) begin
                        word_r       <= word_r + 30'h0000_0001;
                        dst_r        <= dst_r + 64'h0000_0000_0000_0004;
                        words_left_r <= words_left_r - 20'h0_0001;
                        // last word: done only once its host write is taken
                        if (words_left_r == 20'h0_0001) begin
                            fsm_r    <= BPR_FSM_IDLE;
                            status_r <= BPR_ST_DONE;
                        end else begin
                            fsm_r <= BPR_FSM_RUN;
                        end
                    end
                end
                default: fsm_r <= BPR_FSM_IDLE;
            endcase
        end
    end

    // one-word holding register between flash answer and host write
    // cleared whenever the engine leaves wait, so an aborted word is dropped
    always_ff @(posedge clock_i or negedge rst_sync_r) begin
        if (!rst_sync_r) begin
            data_full_r <= 1'b0;
            data_r      <= 32'h0000_0000;
        end else if (sel_wr || fsm_r != BPR_FSM_WAIT) begin
            data_full_r <= 1'b0;
        end else if (fl_rsp_valid_i && !fl_rsp_err_i && !data_full_r) begin
            data_full_r <= 1'b1;
            data_r      <= fl_rsp_data_i;
        end else if (data_full_r && mem_wr_ready_i) begin
            data_full_r <= 1'b0;
        end
    end

    // handshakes are combinational; a select write in the same cycle
    // withdraws them so a stale word is never handed out
    assign fl_req_valid_o = (fsm_r == BPR_FSM_RUN) && !sel_wr;
    assign mem_wr_valid_o = (fsm_r == BPR_FSM_WAIT) && data_full_r && !sel_wr;

    // payloads come straight from flops, one driver per port
    assign fl_req_o       = '{part: sel_r[BPR_SEL_PART], word: word_r};
    assign mem_wr_o       = '{addr: dst_r, data: data_r};
endmodule : bpr_top

// >>> verification/bpr_far_model.sv
// flash array and host memory model facing the copy engine
`timescale 1ns/1ns
module bpr_far_model (
    input  wire logic                 clock_i,
    input  wire logic                 slow_i,
    input  wire logic                 fail_i,
    input  wire logic                 fl_req_valid_i,
    input  wire bpr_pkg::bpr_fl_req_t fl_req_i,
    output logic                      fl_req_ready_o,
    output logic                      fl_rsp_valid_o,
    output logic [31:0]               fl_rsp_data_o,
    output logic                      fl_rsp_err_o,
    input  wire logic                 mem_wr_valid_i,
    input  wire bpr_pkg::bpr_mem_wr_t mem_wr_i,
    output logic                      mem_wr_ready_o
);
    import bpr_pkg::*;
    logic [31:0] mem [logic [63:0]];
    int          n_wr   = 0;
    logic [1:0]  tick_r = 2'h0;
    // slow mode stalls both sides on a free-running tick
    always_ff @(posedge clock_i) tick_r <= tick_r + 2'h1;
    assign fl_req_ready_o = !slow_i || tick_r[0];
    assign mem_wr_ready_o = !slow_i || tick_r[1];
    // one answer per accepted word; idle data line toggles so stale data never looks valid
    always_ff @(posedge clock_i) begin
        fl_rsp_valid_o <= fl_req_valid_i && fl_req_ready_o;
        fl_rsp_err_o   <= fl_req_valid_i && fl_req_ready_o && fail_i;
        fl_rsp_data_o  <= (fl_req_valid_i && fl_req_ready_o) ?
            {fl_req_i.part, 1'b0, fl_req_i.word} ^ 32'hA5A5_0000 : ~fl_rsp_data_o;
    end
    // host buffer keeps every accepted write
    always @(posedge clock_i) if (mem_wr_valid_i && mem_wr_ready_o) begin
        mem[mem_wr_i.addr] = mem_wr_i.data;
        n_wr++;
    end
endmodule : bpr_far_model

// >>> verification/bpr_top_monitor.sv
// port checker for the boot partition read block
`timescale 1ns/1ns
module bpr_top_monitor #(
    parameter bit          SUPPORTED = 1'b1,
    parameter logic [14:0] PART_SIZE = 15'h0001,
    parameter bit          ACTIVE_ID = 1'b0
) (
    input wire logic                  clock_i,
    input wire logic                  rstn_i,
    input wire bpr_pkg::bpr_reg_req_t reg_req_i,
    input wire logic [31:0]           reg_rdata_o,
    input wire logic                  mem_wr_valid_o,
    input wire bpr_pkg::bpr_mem_wr_t  mem_wr_o,
    input wire logic                  mem_wr_ready_i
);
    import bpr_pkg::*;
    default clocking @(posedge clock_i); endclocking
    default disable iff (!rstn_i);
    // decoded register accesses
    wire rd_inf = reg_req_i.rd && reg_req_i.addr == BPR_OFF_INFO;
    wire wr_sel = reg_req_i.wr && reg_req_i.addr == BPR_OFF_SEL;
    wire rd_sel = reg_req_i.rd && reg_req_i.addr == BPR_OFF_SEL;
    busy_on_sel_a: assert property ((SUPPORTED && wr_sel) ##1 rd_inf
        |-> reg_rdata_o[25:24] == 2'b01) else $error("status not busy after select");
    info_fields_a: assert property (SUPPORTED && rd_inf
        |-> reg_rdata_o[31] == ACTIVE_ID && reg_rdata_o[14:0] == PART_SIZE)
        else $error("info fields wrong");
    info_rsvd_a: assert property (rd_inf |-> reg_rdata_o[30:26] == '0
        && reg_rdata_o[23:15] == '0) else $error("info reserved bits set");
    sel_rsvd_a: assert property (rd_sel |-> !reg_rdata_o[30]) else $error("select bit 30 set");
    buf_rsvd_a: assert property (reg_req_i.rd && reg_req_i.addr == BPR_OFF_BUF_LO
        |-> reg_rdata_o[11:0] == '0) else $error("buffer low bits set");
    idle_zero_a: assert property (!reg_req_i.rd |-> reg_rdata_o == '0) else $error("idle data");
    off_zero_a: assert property (!SUPPORTED |-> reg_rdata_o == '0)
        else $error("unsupported build reads nonzero");
    dst_align_a: assert property (mem_wr_valid_o |-> mem_wr_o.addr[1:0] == 2'b00)
        else $error("host write unaligned");
    mem_hold_a: assert property (mem_wr_valid_o && !mem_wr_ready_i && !wr_sel
        |=> mem_wr_valid_o && $stable(mem_wr_o)) else $error("host write dropped");
    cover property (wr_sel);
    cover property (rd_inf && reg_rdata_o[25:24] == 2'b10);
    cover property (rd_inf && reg_rdata_o[25:24] == 2'b11);
    cover property (mem_wr_valid_o && !mem_wr_ready_i);
endmodule : bpr_top_monitor
bind bpr_top bpr_top_monitor #(.SUPPORTED(SUPPORTED), .PART_SIZE(PART_SIZE),
    .ACTIVE_ID(ACTIVE_ID)) i_bpr_top_monitor (
    .clock_i(clock_i), .rstn_i(rstn_i), .reg_req_i(reg_req_i), .reg_rdata_o(reg_rdata_o),
    .mem_wr_valid_o(mem_wr_valid_o), .mem_wr_o(mem_wr_o), .mem_wr_ready_i(mem_wr_ready_i));

// >>> verification/bpr_top_tb.sv
// self-checking bench for the boot partition read block
`timescale 1ns/1ns
module bpr_top_tb;
    import bpr_pkg::*;
    localparam logic [14:0] PSZ = 15'h0001;
    localparam bit          ACT = 1'b1;
    logic clock_i = 1'b0, rstn_i = 1'b0, slow = 1'b0, fail = 1'b0;
    logic [31:0] rdata, rdq, fl_data, rdata_off, rdo, seed = 32'h5CCB;
    logic [63:0] base;
    logic fl_v, fl_rdy, rsp_v, rsp_err, mem_v, mem_rdy;
    bpr_reg_req_t req = '0;
    bpr_fl_req_t  fl_req;
    bpr_mem_wr_t  mem_wr;
    int n_errors = 0, checks_done = 0, i;
    always #20 clock_i = ~clock_i;
    bpr_top #(.SUPPORTED(1'b1), .PART_SIZE(PSZ), .ACTIVE_ID(ACT)) i_bpr_top (
        .clock_i(clock_i), .rstn_i(rstn_i), .reg_req_i(req), .reg_rdata_o(rdata),
        .fl_req_valid_o(fl_v), .fl_req_o(fl_req), .fl_req_ready_i(fl_rdy),
        .fl_rsp_valid_i(rsp_v), .fl_rsp_data_i(fl_data), .fl_rsp_err_i(rsp_err),
        .mem_wr_valid_o(mem_v), .mem_wr_o(mem_wr), .mem_wr_ready_i(mem_rdy), .mem_wr_err_i(1'b0));
    bpr_far_model i_bpr_far_model (.clock_i(clock_i), .slow_i(slow), .fail_i(fail),
        .fl_req_valid_i(fl_v), .fl_req_i(fl_req), .fl_req_ready_o(fl_rdy),
        .fl_rsp_valid_o(rsp_v), .fl_rsp_data_o(fl_data), .fl_rsp_err_o(rsp_err),
        .mem_wr_valid_i(mem_v), .mem_wr_i(mem_wr), .mem_wr_ready_o(mem_rdy));
    // a build without the feature sees the same accesses and must read zero
    if (1'b1) begin : g_off
        bpr_top #(.SUPPORTED(1'b0), .PART_SIZE(PSZ), .ACTIVE_ID(ACT)) i_bpr_top (
            .clock_i(clock_i), .rstn_i(rstn_i), .reg_req_i(req), .reg_rdata_o(rdata_off),
            .fl_req_valid_o(), .fl_req_o(), .fl_req_ready_i(1'b1),
            .fl_rsp_valid_i(1'b0), .fl_rsp_data_i(32'h0000_0000), .fl_rsp_err_i(1'b0),
            .mem_wr_valid_o(), .mem_wr_o(), .mem_wr_ready_i(1'b1), .mem_wr_err_i(1'b0));
    end
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr
    task chk(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            n_errors++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : chk
    // request held from a falling edge until the next access replaces it
    task acc(input logic w, input logic r, input logic [11:0] a, input logic [31:0] d);
        @(negedge clock_i);
        req = '{w, r, a, d};
        #10 rdq = rdata;
        rdo = rdata_off;
    endtask : acc
    // one read: select, busy next cycle, bounded poll, then status, count and buffer
    task run(input logic p, input int ofs, input int len);
        int k, n0, st;
        n0 = i_bpr_far_model.n_wr;
        acc(1'b1, 1'b0, BPR_OFF_SEL, {p, 1'b1, ofs[19:0], len[9:0]});
        acc(1'b0, 1'b1, BPR_OFF_INFO, '0);
        chk(rdq[25:24], 2'b01);
        for (k = 0; k < 40000 && rdq[25:24] == 2'b01; k++) acc(1'b0, 1'b1, BPR_OFF_INFO, '0);
        st = (ofs + len > PSZ * 32 || fail) ? 3 : 2;
        chk(rdq[25:24], st[1:0]);
        chk(rdo, '0);
        if (!fail) chk(32'(i_bpr_far_model.n_wr - n0), st == 3 ? 0 : len * 1024);
        acc(1'b0, 1'b1, BPR_OFF_SEL, '0);
        chk(rdq, {p, 1'b0, ofs[19:0], len[9:0]});
        for (k = 0; k < len * 1024 && st == 2; k++) chk(i_bpr_far_model.mem[base + 4 * k],
            {p, 1'b0, 30'(ofs * 1024 + k)} ^ 32'hA5A5_0000);
    endtask : run
    task finish_test();
        $display("checks %0d errors %0d", checks_done, n_errors);
        if (n_errors == 0 && checks_done > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask : finish_test
    // watchdog well beyond the expected run
    initial begin
        repeat (90000) @(posedge clock_i);
        n_errors++;
        finish_test();
    end
    initial begin
        repeat (10) @(negedge clock_i);
        rstn_i = 1'b1;
        repeat (2) @(negedge clock_i);
        acc(1'b0, 1'b1, BPR_OFF_INFO, '0);
        chk(rdq, {ACT, 16'h0, PSZ});
        chk(rdo, '0);
        for (i = 0; i < 4; i++) begin
            acc(1'b0, 1'b1, BPR_OFF_SEL + 12'(4 * i), '0);
            chk(rdq, '0);
        end
        // random buffer, low bits written as random data and expected dropped
        seed = lfsr(seed);
        base[31:0] = seed;
        seed = lfsr(seed);
        base[63:32] = seed;
        acc(1'b1, 1'b0, BPR_OFF_BUF_LO, base[31:0]);
        acc(1'b1, 1'b0, BPR_OFF_BUF_HI, base[63:32]);
        base[11:0] = 12'h000;
        acc(1'b0, 1'b1, BPR_OFF_BUF_LO, '0);
        chk(rdq, base[31:0]);
        chk(rdo, '0);
        acc(1'b0, 1'b1, BPR_OFF_BUF_HI, '0);
        chk(rdq, base[63:32]);
        slow = 1'b1;
        run(1'b1, 31, 1);
        slow = 1'b0;
        run(1'b0, 0, 2);
        run(1'b0, 31, 2);
        run(1'b0, 0, 0);
        fail = 1'b1;
        run(1'b0, 0, 1);
        // reset in the middle of a copy: status and select register back to zero
        fail = 1'b0;
        acc(1'b1, 1'b0, BPR_OFF_SEL, 32'h0000_0001);
        repeat (6) acc(1'b0, 1'b1, BPR_OFF_INFO, '0);
        chk(rdq[25:24], 2'b01);
        @(negedge clock_i);
        rstn_i = 1'b0;
        repeat (2) @(negedge clock_i);
        rstn_i = 1'b1;
        repeat (2) @(negedge clock_i);
        acc(1'b0, 1'b1, BPR_OFF_INFO, '0);
        chk(rdq, {ACT, 16'h0, PSZ});
        acc(1'b0, 1'b1, BPR_OFF_SEL, '0);
        chk(rdq, '0);
        acc(1'b0, 1'b0, '0, '0);
        finish_test();
    end
endmodule : bpr_top_tb
